// [hw/psg_map.vh]
`ifndef PSG_MAP_VH
`define PSG_MAP_VH

// ---------------------------------------------------------------
// Register word addresses (compared against avs_address[5:2])
// ---------------------------------------------------------------
`define PSG_ADDR_LONG_A       4'h0
`define PSG_ADDR_LONG_B       4'h1
`define PSG_ADDR_SHORT_A      4'h2
`define PSG_ADDR_SHORT_B      4'h3
`define PSG_ADDR_LONG_LEN     4'h4
`define PSG_ADDR_SHORT_LEN    4'h5
`define PSG_ADDR_FRAME_CTRL   4'h6
`define PSG_ADDR_CFG_LONG     4'h7
`define PSG_ADDR_CFG_SHORT    4'h8
`define PSG_ADDR_CONTROL      4'h9
`define PSG_ADDR_STATUS       4'ha

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
// long_symbol_pair_length: [3:0] pattern length, [11:4] burst length a,
// [19:12] burst length b, [20] burst level a, [21] burst level b,
// [22] burst enable a, [23] burst enable b.
`define PSG_LEN_PAT_LSB       0
`define PSG_LEN_BURST_A_LSB   4
`define PSG_LEN_BURST_B_LSB   12
`define PSG_LEN_LEVEL_A_BIT   20
`define PSG_LEN_LEVEL_B_BIT   21
`define PSG_LEN_BEN_A_BIT     22
`define PSG_LEN_BEN_B_BIT     23
// transmit_frame_control: [1:0] leading select, [3:2] trailing select.
// Leading: 0 none, 1 long a, 2 long b, 3 short a.
// Trailing: 0 none, 1 long b, 2 short a, 3 short b.
`define PSG_FC_LEAD_LSB       0
`define PSG_FC_TRAIL_LSB      2
// Configuration set: [15:0] bit-clock divider minus one, [31:16] passed out.
`define PSG_CFG_DIV_LSB       0
`define PSG_CFG_EXTRA_LSB     16
// Control: bit 0 start, bit 1 packet done (both write-one pulses).
`define PSG_CTRL_START_BIT    0
`define PSG_CTRL_DONE_BIT     1

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define PSG_RST_WORD          32'h0000_0000
`define PSG_RST_DIV           16'h0003

`endif

// [hw/psg_serializer.v]
`timescale 1ns/1ps

// ---------------------------------------------------------------
// Shifts one symbol out MSB-first from bit position len, then burst.
// Busy falls with the last bit, so every tick taken while busy emits one bit.
// ---------------------------------------------------------------
module psg_serializer #(
	parameter PAT_W = 16,
	parameter LEN_W = 4,
	parameter BURST_W = 8
) (
	input  wire               core_clk,
	input  wire               arst_n,
	input  wire               load,
	input  wire [PAT_W-1:0]   pattern,
	input  wire [LEN_W-1:0]   len,
	input  wire               burst_en,
	input  wire [BURST_W-1:0] burst_len,
	input  wire               burst_level,
	input  wire               bit_tick,
	output reg                bit_out_q,
	output reg                busy_q
);
	reg [PAT_W-1:0]   pat_q;
	reg [LEN_W-1:0]   idx_q;
	reg               in_burst_q;
	reg [BURST_W:0]   burst_cnt_q;
	reg               lvl_q;

	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pat_q       <= {PAT_W{1'b0}};
			idx_q       <= {LEN_W{1'b0}};
			in_burst_q  <= 1'b0;
			burst_cnt_q <= {(BURST_W+1){1'b0}};
			lvl_q       <= 1'b0;
			bit_out_q   <= 1'b0;
			busy_q      <= 1'b0;
		end
		else if (load)
		begin
			pat_q       <= pattern;
			idx_q       <= len;
			in_burst_q  <= 1'b0;
			burst_cnt_q <= burst_en ? ({1'b0, burst_len} + {{BURST_W{1'b0}}, 1'b1})
			                        : {(BURST_W+1){1'b0}};
			lvl_q       <= burst_level;
			busy_q      <= 1'b1;
		end
		else if (busy_q && bit_tick)
		begin
			if (!in_burst_q)
			begin
				bit_out_q <= pat_q[idx_q];
				if (idx_q != {LEN_W{1'b0}})
					idx_q <= idx_q - {{(LEN_W-1){1'b0}}, 1'b1};
				else if (burst_cnt_q != {(BURST_W+1){1'b0}})
					in_burst_q <= 1'b1;
				else
					busy_q <= 1'b0;
			end
			else
			begin
				bit_out_q   <= lvl_q;
				burst_cnt_q <= burst_cnt_q - {{BURST_W{1'b0}}, 1'b1};
				if (burst_cnt_q == {{BURST_W{1'b0}}, 1'b1})
					busy_q <= 1'b0;
			end
		end
	end
endmodule // psg_serializer

// [hw/psg_symbol_gen.v]
`timescale 1ns/1ps
`include "psg_map.vh"

// Contract
// - Four programmable symbols exist and the two long ones hold patterns of up to sixteen bits.
// - Each long symbol may append a burst of up to 256 bits at a constant zero or one.
// - The two short symbols hold at most eight pattern bits and have no burst.
// - Each pattern is written by software and its least significant bit goes out last.
// - One length register serves the long pair and another serves the short pair.
// - Pattern bits above the programmed length are never sent.
// - Only long a, long b or short a may lead a packet, and only long b, short a or short b may trail it.
// - Long a and b share one configuration set and short a and b share another.
module psg_symbol_gen #(
	parameter LONG_W = 16,
	parameter SHORT_W = 8,
	parameter BURST_W = 8
) (
	input  wire        core_clk,
	input  wire        arst_n,
	input  wire [5:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	output reg         sym_bit_q,
	output reg         sym_valid_q,
	output reg         data_go_q,
	output reg         frame_done_q,
	output reg  [15:0] sym_cfg_q
);
	localparam S_IDLE  = 3'd0;
	localparam S_LEAD  = 3'd1;
	localparam S_DATA  = 3'd2;
	localparam S_TRAIL = 3'd3;
	localparam S_END   = 3'd4;

	reg [31:0] long_a_q, long_b_q, short_a_q, short_b_q;
	reg [31:0] long_len_q, short_len_q, frame_ctrl_q, cfg_long_q, cfg_short_q;
	reg [2:0]  state_q;
	reg        ack_q;
	reg        start_q, done_q;
	reg [15:0] div_cnt_q;
	reg        tick_q;
	reg        load_q;
	reg        emit_q;
	reg        use_long_q;
	reg [LONG_W-1:0] pat_q;
	reg [3:0]  len_q;
	reg        ben_q, blvl_q;
	reg [BURST_W-1:0] blen_q;
	wire       ser_bit, ser_busy;
	wire [3:0] a_idx = avs_address[5:2];
	wire       req   = (avs_read | avs_write) & ~ack_q;

	// ---------------------------------------------------------------
	// Avalon slave: one wait state, writes land on the ack edge.
	// ---------------------------------------------------------------
	function [31:0] bmerge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  be;
		integer i;
		begin
			for (i = 0; i < 4; i = i + 1)
				bmerge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ack_q <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata <= `PSG_RST_WORD;
			long_a_q <= `PSG_RST_WORD;
			long_b_q <= `PSG_RST_WORD;
			short_a_q <= `PSG_RST_WORD;
			short_b_q <= `PSG_RST_WORD;
			long_len_q <= `PSG_RST_WORD;
			short_len_q <= `PSG_RST_WORD;
			frame_ctrl_q <= `PSG_RST_WORD;
			cfg_long_q <= {16'h0000, `PSG_RST_DIV};
			cfg_short_q <= {16'h0000, `PSG_RST_DIV};
			start_q <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			ack_q <= req;
			avs_waitrequest <= ~req;
			start_q <= 1'b0;
			done_q <= 1'b0;
			if (ack_q && avs_write)
			begin
				case (a_idx)
				`PSG_ADDR_LONG_A: long_a_q <= bmerge(long_a_q, avs_writedata, avs_byteenable) & 32'h0000_ffff;
				`PSG_ADDR_LONG_B: long_b_q <= bmerge(long_b_q, avs_writedata, avs_byteenable) & 32'h0000_ffff;
				`PSG_ADDR_SHORT_A: short_a_q <= bmerge(short_a_q, avs_writedata, avs_byteenable) & 32'h0000_00ff;
				`PSG_ADDR_SHORT_B: short_b_q <= bmerge(short_b_q, avs_writedata, avs_byteenable) & 32'h0000_00ff;
				`PSG_ADDR_LONG_LEN: long_len_q <= bmerge(long_len_q, avs_writedata, avs_byteenable) & 32'h00ff_ffff;
				`PSG_ADDR_SHORT_LEN: short_len_q <= bmerge(short_len_q, avs_writedata, avs_byteenable) & 32'h0000_0007;
				`PSG_ADDR_FRAME_CTRL: frame_ctrl_q <= bmerge(frame_ctrl_q, avs_writedata, avs_byteenable) & 32'h0000_000f;
				`PSG_ADDR_CFG_LONG: cfg_long_q <= bmerge(cfg_long_q, avs_writedata, avs_byteenable);
				`PSG_ADDR_CFG_SHORT: cfg_short_q <= bmerge(cfg_short_q, avs_writedata, avs_byteenable);
				`PSG_ADDR_CONTROL:
				begin
					start_q <= avs_writedata[`PSG_CTRL_START_BIT] & avs_byteenable[0];
					done_q  <= avs_writedata[`PSG_CTRL_DONE_BIT] & avs_byteenable[0];
				end
				default: ;
				endcase
			end
			if (req && avs_read)
			begin
				case (a_idx)
				`PSG_ADDR_LONG_A: avs_readdata <= long_a_q;
				`PSG_ADDR_LONG_B: avs_readdata <= long_b_q;
				`PSG_ADDR_SHORT_A: avs_readdata <= short_a_q;
				`PSG_ADDR_SHORT_B: avs_readdata <= short_b_q;
				`PSG_ADDR_LONG_LEN: avs_readdata <= long_len_q;
				`PSG_ADDR_SHORT_LEN: avs_readdata <= short_len_q;
				`PSG_ADDR_FRAME_CTRL: avs_readdata <= frame_ctrl_q;
				`PSG_ADDR_CFG_LONG: avs_readdata <= cfg_long_q;
				`PSG_ADDR_CFG_SHORT: avs_readdata <= cfg_short_q;
				`PSG_ADDR_STATUS: avs_readdata <= {27'h0, ser_busy, state_q, 1'b0} >> 1;
				default: avs_readdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Bit clock from the active configuration set.
	// ---------------------------------------------------------------
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			div_cnt_q <= 16'h0000;
			tick_q <= 1'b0;
		end
		else if (div_cnt_q >= (use_long_q ? cfg_long_q[15:0] : cfg_short_q[15:0]))
		begin
			div_cnt_q <= 16'h0000;
			tick_q <= 1'b1;
		end
		else
		begin
			div_cnt_q <= div_cnt_q + 16'h0001;
			tick_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Frame sequencer.
	// ---------------------------------------------------------------
	task pick;
		input [1:0] sel;
		input       trail;
		begin
			case (trail ? sel + 2'd1 : sel)
			2'd1: begin use_long_q <= 1'b1; pat_q <= long_a_q[15:0]; len_q <= long_len_q[3:0];
				ben_q <= long_len_q[`PSG_LEN_BEN_A_BIT]; blvl_q <= long_len_q[`PSG_LEN_LEVEL_A_BIT];
				blen_q <= long_len_q[11:4]; end
			2'd2: begin use_long_q <= 1'b1; pat_q <= long_b_q[15:0]; len_q <= long_len_q[3:0];
				ben_q <= long_len_q[`PSG_LEN_BEN_B_BIT]; blvl_q <= long_len_q[`PSG_LEN_LEVEL_B_BIT];
				blen_q <= long_len_q[19:12]; end
			2'd3: begin use_long_q <= 1'b0; pat_q <= {8'h00, short_a_q[7:0]};
				len_q <= {1'b0, short_len_q[2:0]}; ben_q <= 1'b0; blvl_q <= 1'b0; blen_q <= 8'h00; end
			default: begin use_long_q <= 1'b0; pat_q <= {8'h00, short_b_q[7:0]};
				len_q <= {1'b0, short_len_q[2:0]}; ben_q <= 1'b0; blvl_q <= 1'b0; blen_q <= 8'h00; end
			endcase
		end
	endtask

	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= S_IDLE;
			load_q <= 1'b0;
			emit_q <= 1'b0;
			use_long_q <= 1'b1;
			pat_q <= 16'h0000;
			len_q <= 4'h0;
			ben_q <= 1'b0;
			blvl_q <= 1'b0;
			blen_q <= 8'h00;
			data_go_q <= 1'b0;
			frame_done_q <= 1'b0;
			sym_valid_q <= 1'b0;
			sym_bit_q <= 1'b0;
			sym_cfg_q <= 16'h0000;
		end
		else
		begin
			load_q <= 1'b0;
			frame_done_q <= 1'b0;
			// The serializer updates its bit on the tick edge, so the strobe
			// trails by one cycle to pair each strobe with the fresh bit.
			emit_q <= ser_busy & tick_q;
			sym_bit_q <= ser_bit;
			sym_valid_q <= emit_q;
			sym_cfg_q <= use_long_q ? cfg_long_q[31:16] : cfg_short_q[31:16];
			case (state_q)
			S_IDLE:
				if (start_q)
				begin
					if (frame_ctrl_q[1:0] != 2'd0)
					begin
						pick(frame_ctrl_q[1:0], 1'b0);
						load_q <= 1'b1;
						state_q <= S_LEAD;
					end
					else
					begin
						data_go_q <= 1'b1;
						state_q <= S_DATA;
					end
				end
			S_LEAD:
				if (!load_q && !ser_busy && !emit_q)
				begin
					data_go_q <= 1'b1;
					state_q <= S_DATA;
				end
			S_DATA:
				if (done_q)
				begin
					data_go_q <= 1'b0;
					if (frame_ctrl_q[3:2] != 2'd0)
					begin
						pick(frame_ctrl_q[3:2], 1'b1);
						load_q <= 1'b1;
						state_q <= S_TRAIL;
					end
					else
						state_q <= S_END;
				end
			S_TRAIL:
				if (!load_q && !ser_busy && !emit_q)
					state_q <= S_END;
			S_END:
			begin
				frame_done_q <= 1'b1;
				state_q <= S_IDLE;
			end
			default: state_q <= S_IDLE;
			endcase
		end
	end

	psg_serializer #(
		.PAT_W   (LONG_W),
		.LEN_W   (4),
		.BURST_W (BURST_W)
	) u_ser (
		.core_clk    (core_clk),
		.arst_n      (arst_n),
		.load        (load_q),
		.pattern     (pat_q),
		.len         (len_q),
		.burst_en    (ben_q),
		.burst_len   (blen_q),
		.burst_level (blvl_q),
		.bit_tick    (tick_q),
		.bit_out_q   (ser_bit),
		.busy_q      (ser_busy)
	);
endmodule // psg_symbol_gen

// [tb/psg_symbol_gen_props.sv]
`timescale 1ns/1ps
// ----
// Bus and link checks
// ----
module psg_symbol_gen_props (
	input wire        core_clk,
	input wire        arst_n,
	input wire [5:0]  avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_readdata,
	input wire        avs_waitrequest,
	input wire        sym_valid_q,
	input wire        data_go_q,
	input wire        frame_done_q
);
	wire [3:0] idx = avs_address[5:2];
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	sequence s_take;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_rd;
		avs_read && avs_waitrequest;
	endsequence
	a_req_answer: assert property (s_take |=> !avs_waitrequest)
		else $error("request not answered next cycle");
	a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_idle_wait: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
		else $error("answer without request");
	a_long_mask: assert property (s_rd ##0 idx < 4'h2 |=> avs_readdata[31:16] == 16'h0)
		else $error("long pattern wider than 16 bits");
	a_short_mask: assert property (s_rd ##0 (idx == 4'h2 || idx == 4'h3) |=> avs_readdata[31:8] == 24'h0)
		else $error("short pattern wider than 8 bits");
	a_len_mask: assert property (s_rd ##0 idx == 4'h5 |=> avs_readdata[31:3] == 29'h0)
		else $error("short length wider than 3 bits");
	a_unmapped_zero: assert property (s_rd ##0 idx > 4'ha |=> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_sym_no_data: assert property (!(sym_valid_q && data_go_q))
		else $error("symbol bit during packet data");
	a_done_pulse: assert property (frame_done_q |=> !frame_done_q)
		else $error("frame done longer than one cycle");
	a_done_no_go: assert property (frame_done_q |-> !data_go_q)
		else $error("frame done while data flows");
endmodule // psg_symbol_gen_props

bind psg_symbol_gen psg_symbol_gen_props chk_u (
	.core_clk        (core_clk),
	.arst_n          (arst_n),
	.avs_address     (avs_address),
	.avs_read        (avs_read),
	.avs_write       (avs_write),
	.avs_readdata    (avs_readdata),
	.avs_waitrequest (avs_waitrequest),
	.sym_valid_q     (sym_valid_q),
	.data_go_q       (data_go_q),
	.frame_done_q    (frame_done_q)
);

// [tb/psg_tx_model.sv]
`timescale 1ns/1ps
// ----
// Modulator side: logs every symbol bit it is handed
// ----
module psg_tx_model (
	input  wire        core_clk,
	input  wire        arst_n,
	input  wire        clr,
	input  wire        sym_bit_q,
	input  wire        sym_valid_q,
	input  wire        frame_done_q,
	input  wire [15:0] sym_cfg_q,
	output reg  [63:0] bits_q,
	output reg  [15:0] cnt_q,
	output reg  [15:0] cfg_q,
	output reg  [7:0]  ends_q
);
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n || clr)
		begin
			bits_q <= 64'h0;
			cnt_q <= 16'h0;
			cfg_q <= 16'h0;
			ends_q <= 8'h0;
		end
		else
		begin
			if (sym_valid_q)
			begin
				bits_q <= {bits_q[62:0], sym_bit_q};
				cnt_q <= cnt_q + 16'h1;
				cfg_q <= sym_cfg_q;
			end
			if (frame_done_q)
				ends_q <= ends_q + 8'h1;
		end
	end
endmodule // psg_tx_model

// [tb/tb.sv]
`timescale 1ns/1ps
// ----
// Random frames over every lead and trail choice
// ----
module tb;
	reg         core_clk = 1'b0;
	reg         arst_n = 1'b0;
	reg  [5:0]  avs_address = 6'h0;
	reg         avs_read = 1'b0;
	reg         avs_write = 1'b0;
	reg  [31:0] avs_writedata = 32'h0;
	reg  [3:0]  avs_byteenable = 4'hf, be = 4'hf;
	reg         p_clr = 1'b0;
	wire [31:0] avs_readdata;
	wire        avs_waitrequest, sym_bit_q, sym_valid_q, data_go_q, frame_done_q;
	wire [15:0] sym_cfg_q, p_cnt, p_cfg;
	wire [63:0] p_bits;
	wire [7:0]  p_ends;
	reg  [31:0] seed = 32'h7a65, rd, r, cfgw[2];
	reg  [15:0] pat[4];
	reg  [23:0] lenl;
	reg  [2:0]  lens;
	reg  [63:0] ew;
	integer     en, i, j, n_fail = 0, check_count = 0;
	always #10 core_clk = ~core_clk;
	psg_symbol_gen dut_u (.core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.sym_bit_q(sym_bit_q), .sym_valid_q(sym_valid_q), .data_go_q(data_go_q),
		.frame_done_q(frame_done_q), .sym_cfg_q(sym_cfg_q));
	psg_tx_model mdl_u (.core_clk(core_clk), .arst_n(arst_n), .clr(p_clr), .sym_bit_q(sym_bit_q),
		.sym_valid_q(sym_valid_q), .frame_done_q(frame_done_q), .sym_cfg_q(sym_cfg_q),
		.bits_q(p_bits), .cnt_q(p_cnt), .cfg_q(p_cfg), .ends_q(p_ends));
	function [31:0] xs();
		begin
			seed = seed ^ (seed << 13);
			seed = seed ^ (seed >> 17);
			seed = seed ^ (seed << 5);
			xs = seed;
		end
	endfunction
	function [31:0] msk(input integer a);
		msk = a < 2 ? 32'hffff : a < 4 ? 32'hff : a == 4 ? 32'hffffff : a == 5 ? 32'h7
			: a == 6 ? 32'hf : 32'h0;
	endfunction
	// Expected bits: pattern from bit n down to 0, then the burst.
	function automatic void add_sym(input integer s);
		integer n, b, k;
		n = s < 2 ? lenl[3:0] : lens;
		for (k = n; k >= 0; k = k - 1) begin ew = {ew[62:0], pat[s][k]}; en = en + 1; end
		b = s ? lenl[19:12] : lenl[11:4];
		if (s < 2 && lenl[22 + s])
			for (k = 0; k <= b; k = k + 1) begin ew = {ew[62:0], lenl[20 + s]}; en = en + 1; end
	endfunction
	task final_report;
		begin
			$display("checks %0d fails %0d", check_count, n_fail);
			if (n_fail == 0 && check_count > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	task chk(input [8*6:1] nm, input [63:0] e, input [63:0] g);
		begin
			check_count = check_count + 1;
			if (g !== e)
			begin
				n_fail = n_fail + 1;
				$display("mismatch %0s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task lim(input ok);
		if (!ok)
		begin
			n_fail = n_fail + 1;
			final_report;
		end
	endtask
	task bus(input w, input [3:0] a, input [31:0] d);
		integer k;
		begin
			avs_address <= {a, 2'b00};
			avs_write <= w;
			avs_read <= !w;
			avs_writedata <= d;
			avs_byteenable <= be;
			k = 0;
			@(posedge core_clk);
			while (avs_waitrequest !== 1'b0 && k < 50)
			begin
				@(posedge core_clk);
				k = k + 1;
			end
			lim(k < 50);
			rd = avs_readdata;
			avs_write <= 1'b0;
			avs_read <= 1'b0;
			@(posedge core_clk);
		end
	endtask
	task frame(input [1:0] ld, input [1:0] tr);
		integer k;
		begin
			ew = 64'h0;
			en = 0;
			p_clr <= 1'b1;
			@(posedge core_clk);
			p_clr <= 1'b0;
			if (ld != 2'h0) add_sym(ld - 1);
			bus(1'b1, 4'h9, 32'h1);
			for (k = 0; k < 9000 && data_go_q !== 1'b1; k = k + 1) @(posedge core_clk);
			lim(k < 9000);
			chk("lead", ew, p_bits);
			chk("lead_n", en, p_cnt);
			if (ld != 2'h0) chk("cfg", cfgw[ld == 2'h3][31:16], p_cfg);
			if (tr != 2'h0) add_sym(tr);
			bus(1'b1, 4'h9, 32'h2);
			for (k = 0; k < 9000 && p_ends == 8'h0; k = k + 1) @(posedge core_clk);
			lim(k < 9000);
			chk("all", ew, p_bits);
			chk("all_n", en, p_cnt);
			chk("ends", 1, p_ends);
			if (tr != 2'h0) chk("cfg_t", cfgw[tr != 2'h1][31:16], p_cfg);
		end
	endtask
	initial
	begin
		repeat (12) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		for (i = 0; i < 16; i = i + 1)
		begin
			bus(1'b0, i, 32'h0);
			chk("reset", (i == 7 || i == 8) ? 3 : 0, rd);
			if (i < 7 || i > 10)
			begin
				bus(1'b1, i, 32'hffffffff);
				bus(1'b0, i, 32'h0);
				chk("mask", msk(i), rd);
				if (i == 0)
				begin
					be = 4'h2;
					bus(1'b1, 4'h0, 32'h0);
					be = 4'hf;
					bus(1'b0, 4'h0, 32'h0);
					chk("lane", 32'hff, rd);
				end
			end
		end
		$display("test regs done");
		for (i = 0; i < 16; i = i + 1)
		begin
			for (j = 0; j < 4; j = j + 1)
			begin
				r = xs();
				pat[j] = j < 2 ? r[15:0] : {8'h0, r[7:0]};
				bus(1'b1, j, r);
			end
			r = xs();
			lenl = r[23:0];
			if (i == 5)
			begin
				lenl[19:12] = 8'hff;
				lenl[23] = 1'b1;
			end
			lens = r[26:24];
			bus(1'b1, 4'h4, {8'h0, lenl});
			bus(1'b1, 4'h5, {29'h0, lens});
			r = xs();
			cfgw[0] = {r[15:0], 16'h0};
			cfgw[1] = {r[31:16], 16'h1};
			bus(1'b1, 4'h7, cfgw[0]);
			bus(1'b1, 4'h8, cfgw[1]);
			bus(1'b1, 4'h6, {28'h0, i[1:0], i[3:2]});
			frame(i[3:2], i[1:0]);
			$display("test frame %0d done", i);
		end
		final_report;
	end
endmodule // tb
